// File: core/adc_cfg_params.svh
// Constants for the converter pin and clock configuration block
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH
`define PCFG_RESET 3'h0
`define DIV_2 2'h0
`define DIV_8 2'h1
`define DIV_32 2'h2
`define DIV_RC 2'h3
`define OSC_PER_2 6'h02
`define OSC_PER_8 6'h08
`define OSC_PER_32 6'h20
`define CLK_PERIOD_NS 10
`define RC_BIT_TIME_NS 4000
`define RC_BIT_CYCLES (`RC_BIT_TIME_NS / `CLK_PERIOD_NS)
`define HALF_BITS_PER_CONV 5'h13
`endif

// File: core/adc_cfg_pkg.sv
// Types for the converter pin and clock configuration block
package adc_cfg_pkg;
  typedef struct packed {
    logic [5:0] a;
    logic [2:0] e;
  } port_dir_s;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONV
  } conv_state_e;
endpackage : adc_cfg_pkg

// File: core/adc_pin_and_clock_config.sv
// Converter pin mapping, port read masking and conversion clock control
//
// Summary of operation
// - Pin analog or digital role comes from config field and direction bits.
// - A pin driven as output converts its own driven digital level.
// - Conversion start and run ignore channel select and direction bits.
// - Port reads return zero on pins configured as analog inputs.
// - A digital input pin still converts its analog level when selected.
// - Clock select 00/01/10/11 gives 2, 8, 32 periods or RC source.
// - RC selection gives 400 ref_clk cycles per bit, 4 us only at a 10 ns clock.
// - Config field resets to 000 on all resets, kept across sleep wake.
// - Each conversion lasts nine and a half bit times; conv_start while busy restarts the current half-bit timer.
`timescale 1ns/1ps
`include "adc_cfg_params.svh"
module adc_pin_and_clock_config
  import adc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Configuration
  input wire logic cfg_write,
  input wire logic [2:0] cfg_wdata,
  input wire adc_cfg_pkg::port_dir_s pin_dir,
  input wire logic [1:0] conversion_clock_select,
  input wire logic [2:0] channel_select,
  // Port pins
  input wire logic [5:0] port_a_pins,
  input wire logic [2:0] port_e_pins,
  input wire logic [5:0] port_a_out,
  input wire logic [2:0] port_e_out,
  input wire logic [7:0] pin_analog_level,
  // Conversion control
  input wire logic conv_start,
  // Outputs
  output logic [2:0] converter_port_config_reg,
  output logic [7:0] analog_pin_mask,
  output logic [5:0] port_a_read,
  output logic [2:0] port_e_read,
  output logic [7:0] sampled_level,
  output logic bit_tick,
  output logic conv_busy,
  output logic conv_done
);
  import adc_cfg_pkg::*;

  logic [7:0] next_mask;
  logic [7:0] dir_all;
  logic [7:0] out_all;
  logic [5:0] div_cnt;
  logic [5:0] div_len;
  logic [8:0] rc_cnt;
  logic [4:0] half_cnt;
  logic half_tick;
  conv_state_e state;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_port_config_reg <= `PCFG_RESET;
    end else if (cfg_write) begin
      converter_port_config_reg <= cfg_wdata;
    end
  end

  assign dir_all = {pin_dir.e, pin_dir.a[5], pin_dir.a[3:0]};
  assign out_all = {port_e_out, port_a_out[5], port_a_out[3:0]};

  always_comb begin
    case (converter_port_config_reg)
      3'h0, 3'h1: next_mask = 8'hFF;
      3'h2: next_mask = 8'h1F;
      3'h3: next_mask = 8'h17;
      3'h4: next_mask = 8'h0B;
      3'h5: next_mask = 8'h03;
      default: next_mask = 8'h00;
    endcase
    next_mask = next_mask & dir_all;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_pin_mask <= 8'h00;
    end else begin
      analog_pin_mask <= next_mask;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_read <= 6'h00;
      port_e_read <= 3'h0;
    end else begin
      port_a_read <= port_a_pins & ~{next_mask[4], 1'b0, next_mask[3:0]};
      port_e_read <= port_e_pins & ~next_mask[7:5];
    end
  end

  // Per-pin sample source
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          sampled_level[i] <= 1'b0;
        end else if (!dir_all[i]) begin
          sampled_level[i] <= out_all[i];
        end else begin
          sampled_level[i] <= pin_analog_level[i];
        end
      end
    end
  endgenerate

  always_comb begin
    case (conversion_clock_select)
      `DIV_2: div_len = `OSC_PER_2;
      `DIV_8: div_len = `OSC_PER_8;
      default: div_len = `OSC_PER_32;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 6'h00;
      rc_cnt <= 9'h000;
    end else if (state == ST_IDLE || conv_start) begin
      div_cnt <= 6'h00;
      rc_cnt <= 9'h000;
    end else begin
      div_cnt <= (div_cnt == (div_len >> 1) - 6'h01) ? 6'h00 : div_cnt + 6'h01;
      rc_cnt <= (rc_cnt == 9'((`RC_BIT_CYCLES / 2) - 1)) ? 9'h000 : rc_cnt + 9'h001;
    end
  end

  assign half_tick = (state == ST_CONV) && ((conversion_clock_select == `DIV_RC) ?
    (rc_cnt == 9'((`RC_BIT_CYCLES / 2) - 1)) : (div_cnt == (div_len >> 1) - 6'h01));
  assign bit_tick = half_tick && half_cnt[0];

  // nine and a half bit times
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      half_cnt <= 5'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (conv_start) begin
            state <= ST_CONV;
            half_cnt <= 5'h00;
          end
        end
        default: begin
          if (half_tick) begin
            if (half_cnt == `HALF_BITS_PER_CONV - 5'h01) begin
              state <= ST_IDLE;
              conv_done <= 1'b1;
            end
            half_cnt <= half_cnt + 5'h01;
          end
        end
      endcase
    end
  end

  assign conv_busy = (state == ST_CONV);

  // Assertions
  AST_CFG_RESET: assert property (@(posedge ref_clk)
    $rose(arst_n) |-> converter_port_config_reg == 3'h0) else $error("config not reset");
  AST_CFG_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !$past(cfg_write) |-> $stable(converter_port_config_reg))
    else $error("config changed without write");
  AST_READ_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(arst_n) |-> ((port_e_read & analog_pin_mask[7:5]) == 3'h0) &&
    ((port_a_read & {analog_pin_mask[4], 1'b0, analog_pin_mask[3:0]}) == 6'h00))
    else $error("analog pin read nonzero");
  AST_MASK_DIR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ##1 ((analog_pin_mask & ~$past(dir_all)) == 8'h00))
    else $error("output pin marked analog");
  AST_OUT_LEVEL: assert property (@(posedge ref_clk) disable iff (!arst_n)
    arst_n && !dir_all[0] |=> sampled_level[0] == $past(out_all[0]))
    else $error("output level not sampled");
  AST_IN_LEVEL: assert property (@(posedge ref_clk) disable iff (!arst_n)
    arst_n && dir_all[1] |=> sampled_level[1] == $past(pin_analog_level[1]))
    else $error("input level not sampled");
  AST_START: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (conv_start && !conv_busy) |=> conv_busy) else $error("start ignored");
  AST_DIV2: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (conv_start && !conv_busy && conversion_clock_select == 2'h0) ##1
    (conversion_clock_select == 2'h0) [*8] |-> ##12 conv_done)
    else $error("div2 conversion length wrong");
  AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    conv_done |=> !conv_done) else $error("done not one cycle");
  AST_TICK_BUSY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bit_tick |-> conv_busy) else $error("tick while idle");
  AST_DIV8_BIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (bit_tick && conversion_clock_select == 2'h1) |=> (!bit_tick) [*7])
    else $error("div8 bit time wrong");
  COV_START: cover property (@(posedge ref_clk) conv_start && !conv_busy);
  COV_DONE: cover property (@(posedge ref_clk) conv_done);
  COV_RC: cover property (@(posedge ref_clk) conv_busy && conversion_clock_select == 2'h3);
  COV_DIV8: cover property (@(posedge ref_clk) bit_tick && conversion_clock_select == 2'h1);
  COV_PART_MASK: cover property (@(posedge ref_clk) analog_pin_mask == 8'h0B);
endmodule : adc_pin_and_clock_config

// File: testbench/analog_source_model.sv
// Analog source stand-in driving the converter pins
`timescale 1ns/1ps
module analog_source_model (
  // Requested levels
  input wire logic [7:0] level_set,
  input wire logic [5:0] digital_a,
  input wire logic [2:0] digital_e,
  // Pins
  output logic [7:0] pin_analog_level,
  output logic [5:0] port_a_pins,
  output logic [2:0] port_e_pins
);
  assign pin_analog_level = level_set;
  assign port_a_pins = digital_a;
  assign port_e_pins = digital_e;
endmodule : analog_source_model

// File: testbench/tb_adc_pin_and_clock_config.sv
// Bench for the converter pin and clock configuration block
`timescale 1ns/1ps
`include "adc_cfg_params.svh"
module tb_adc_pin_and_clock_config;
  import adc_cfg_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_write = 1'b0;
  logic [2:0] cfg_wdata = 3'h0;
  port_dir_s pin_dir = '{a: 6'h3F, e: 3'h7};
  logic [1:0] conversion_clock_select = 2'h0;
  logic [2:0] channel_select = 3'h0;
  logic [5:0] port_a_out = 6'h2A;
  logic [2:0] port_e_out = 3'h5;
  logic conv_start = 1'b0;
  logic [7:0] pin_analog_level, analog_pin_mask, sampled_level;
  logic [5:0] port_a_pins, port_a_read;
  logic [2:0] port_e_pins, port_e_read, converter_port_config_reg;
  logic bit_tick, conv_busy, conv_done;
  logic [7:0] tab [8] = '{8'hFF, 8'hFF, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
  int lens [4] = '{`OSC_PER_2, `OSC_PER_8, `OSC_PER_32, `RC_BIT_CYCLES};
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int i;
  always #5 ref_clk = ~ref_clk;
  analog_source_model src (.level_set(8'h5C), .digital_a(6'h3F), .digital_e(3'h7),
    .pin_analog_level(pin_analog_level), .port_a_pins(port_a_pins), .port_e_pins(port_e_pins));
  adc_pin_and_clock_config dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_write(cfg_write),
    .cfg_wdata(cfg_wdata), .pin_dir(pin_dir), .conversion_clock_select(conversion_clock_select),
    .channel_select(channel_select), .port_a_pins(port_a_pins), .port_e_pins(port_e_pins),
    .port_a_out(port_a_out), .port_e_out(port_e_out), .pin_analog_level(pin_analog_level),
    .conv_start(conv_start), .converter_port_config_reg(converter_port_config_reg),
    .analog_pin_mask(analog_pin_mask), .port_a_read(port_a_read), .port_e_read(port_e_read),
    .sampled_level(sampled_level), .bit_tick(bit_tick), .conv_busy(conv_busy),
    .conv_done(conv_done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic set_cfg(input logic [2:0] v, input port_dir_s d);
    @(posedge ref_clk);
    cfg_write <= 1'b1;
    cfg_wdata <= v;
    pin_dir <= d;
    @(posedge ref_clk);
    cfg_write <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : set_cfg
  task automatic run_conv(input logic [1:0] sel);
    int n;
    int t;
    @(posedge ref_clk);
    conversion_clock_select <= sel;
    channel_select <= channel_select + 3'h3;
    @(posedge ref_clk);
    conv_start <= 1'b1;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    n = 0;
    t = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n == 1) chk(16'(conv_busy), 16'h1);
      if (bit_tick === 1'b1) t++;
    end while (conv_done !== 1'b1 && n < 5000);
    chk(16'(n), 16'(19 * lens[sel] / 2));
    chk(16'(t), 16'h9);
    chk(16'(conv_busy), 16'h0);
  endtask : run_conv
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(16'(converter_port_config_reg), 16'h0);
    for (i = 0; i < 8; i++) begin
      set_cfg(3'(i), '{a: 6'h3F, e: 3'h7});
      chk(16'(analog_pin_mask), 16'(tab[i]));
      chk(16'(port_a_read), 16'(6'h3F & ~{tab[i][4], 1'b0, tab[i][3:0]}));
      chk(16'(port_e_read), 16'(3'h7 & ~tab[i][7:5]));
    end
    $display("Test pin decode done");
    set_cfg(3'h0, '{a: 6'h00, e: 3'h0});
    chk(16'(analog_pin_mask), 16'h0);
    chk(16'(sampled_level), 16'hBA);
    set_cfg(3'h7, '{a: 6'h3F, e: 3'h7});
    chk(16'(sampled_level), 16'h5C);
    $display("Test sampling done");
    @(posedge ref_clk);
    pin_dir <= '{a: 6'h15, e: 3'h2};
    for (i = 0; i < 4; i++) begin
      run_conv(2'(i));
    end
    run_conv(2'h0);
    $display("Test conversion timing done");
    set_cfg(3'h5, '{a: 6'h3F, e: 3'h7});
    chk(16'(converter_port_config_reg), 16'h5);
    arst_n <= 1'b0;
    #1;
    chk(16'(converter_port_config_reg), 16'h0);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    $display("Test reset done");
    tally_and_finish();
  end
endmodule : tb_adc_pin_and_clock_config
